// [logic/hwdog_defs.svh]
// offsets, field positions, reset values and timing counts of the watchdog
//------------------------------------------------------------------------
// Functional notes
// [R1] watchdog starts disabled after every reset
// [R2] key 1EH then E1H enables counting
// [R3] enabled counter advances once per machine cycle
// [R4] no disable except reset or own overflow
// [R5] each complete key pair clears the count
// [R6] 14-bit counter overflows at 3FFFH, resets device
// [R7] overflow drives 96-clock high reset pulse
// [R8] key register write-only, counter hidden
// [R9] 7-bit prescaler extends time-out, separately programmed
// [R10] machine cycle equals twelve oscillator periods
// [R11] wrong second value discards partial key
//------------------------------------------------------------------------
`ifndef HWDOG_DEFS_SVH
`define HWDOG_DEFS_SVH

// register indices; byte address is four times the index
`define HWDOG_KEY_IDX 10'h0A6
`define HWDOG_PRE_IDX 10'h0A7
`define HWDOG_STAT_IDX 10'h0A8

// key values
`define HWDOG_KEY_FIRST 8'h1E
`define HWDOG_KEY_SECOND 8'hE1

// prescale field and reset value
`define HWDOG_PRE_SEL_MSB 2
`define HWDOG_PRE_SEL_RST 3'h0

// status field positions
`define HWDOG_STAT_EN_BIT 0
`define HWDOG_STAT_ARM_BIT 1
`define HWDOG_STAT_RST_BIT 2

// counter terminal value
`define HWDOG_CNT_TOP 14'h3FFF

// timing: pclk is the oscillator, 5 ns
`define HWDOG_PCLK_NS 5
`define HWDOG_OSC_PER_MC 12
`define HWDOG_MC_NS (`HWDOG_OSC_PER_MC * `HWDOG_PCLK_NS)
`define HWDOG_MC_CYC (`HWDOG_MC_NS / `HWDOG_PCLK_NS)
`define HWDOG_RST_CYC 96

`endif

// [logic/hwdog_pkg.sv]
// types shared by the watchdog block
package hwdog_pkg;

  // key sequence tracker, one bit so trivially gray
  typedef enum logic [0:0]
  {
    HWDOG_KEY_IDLE = 1'b0,
    HWDOG_KEY_ARMED = 1'b1
  } hwdog_key_e;

  // apb request from the master
  typedef struct packed
  {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
  } hwdog_apb_req_s;

  // apb answer to the master
  typedef struct packed
  {
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } hwdog_apb_rsp_s;

  // whole state of the watchdog
  typedef struct packed
  {
    hwdog_apb_rsp_s rsp;
    logic en;
    hwdog_key_e key;
    logic [3:0] mc_div;
    logic [6:0] pre;
    logic [2:0] pre_sel;
    logic [13:0] cnt;
    logic [6:0] rst_cnt;
    logic wdog_rst;
  } hwdog_state_s;

endpackage

// [logic/hwdog_top.sv]
// hardware watchdog with apb register access and reset pulse output
`timescale 1ns/1ps
`include "hwdog_defs.svh"

module hwdog_top
(
  input wire logic pclk,
  input wire logic presetn,
  input wire hwdog_pkg::hwdog_apb_req_s apb_req,
  output hwdog_pkg::hwdog_apb_rsp_s apb_rsp,
  output logic wdog_rst
);
  import hwdog_pkg::*;

  //----------------------------------------------------------------------
  // state and decode
  //----------------------------------------------------------------------

  // registered state and its next value
  hwdog_state_s st_r;
  hwdog_state_s st_nxt;

  // one pclk pulse per machine cycle
  logic mc_tick;
  // prescaler wrap mask chosen by the config field
  logic [6:0] pre_mask;
  // counter advance enable
  logic cnt_tick;
  // apb access phase completing this edge
  logic acc;
  // decoded writes and reads
  logic wr_key;
  logic wr_pre;
  logic rd_hit;
  // complete key pair seen this edge
  logic key_done;

  localparam logic [3:0] MC_LAST = 4'(`HWDOG_MC_CYC - 1);
  localparam logic [6:0] RST_LAST = 7'(`HWDOG_RST_CYC - 1);

  // the access completes on the edge where pready was already high
  assign acc = apb_req.psel && apb_req.penable && st_r.rsp.pready;

  // writes only count when the low byte lane is strobed
  assign wr_key = acc && apb_req.pwrite && apb_req.pstrb[0]
                  && (apb_req.paddr[11:2] == `HWDOG_KEY_IDX);
  assign wr_pre = acc && apb_req.pwrite && apb_req.pstrb[0]
                  && (apb_req.paddr[11:2] == `HWDOG_PRE_IDX);

  // every mapped index, used for the error answer
  assign rd_hit = (apb_req.paddr[11:2] == `HWDOG_KEY_IDX)
                  || (apb_req.paddr[11:2] == `HWDOG_PRE_IDX)
                  || (apb_req.paddr[11:2] == `HWDOG_STAT_IDX);

  // [R10] twelve oscillator periods
  assign mc_tick = (st_r.mc_div == MC_LAST);

  // eight-bit shift so sel 7 still yields the 7-bit all-ones mask
  // [R9] prescale extends by two to the sel
  assign pre_mask = 7'((8'h01 << st_r.pre_sel) - 8'h01);
  assign cnt_tick = st_r.en && mc_tick && (st_r.pre == pre_mask);

  // [R2] pair completes only from armed state
  assign key_done = wr_key && (st_r.key == HWDOG_KEY_ARMED)
                    && (apb_req.pwdata[7:0] == `HWDOG_KEY_SECOND)
                    && !st_r.wdog_rst;

  //----------------------------------------------------------------------
  // next-state logic
  //----------------------------------------------------------------------

  // one pass computes the whole next state
  always_comb
  begin
    st_nxt = st_r;

    // answer in the cycle after setup: one wait-free access phase
    st_nxt.rsp.pready = apb_req.psel && !apb_req.penable;
    st_nxt.rsp.pslverr = 1'b0;

    // setup phase prepares the read data and error flag
    if (apb_req.psel && !apb_req.penable)
    begin
      st_nxt.rsp.prdata = 32'h00000000;
      st_nxt.rsp.pslverr = !rd_hit;
      if (!apb_req.pwrite)
      begin
        // [R8] key register and counter read zero
        if (apb_req.paddr[11:2] == `HWDOG_PRE_IDX)
        begin
          st_nxt.rsp.prdata[`HWDOG_PRE_SEL_MSB:0] = st_r.pre_sel;
        end
        else if (apb_req.paddr[11:2] == `HWDOG_STAT_IDX)
        begin
          st_nxt.rsp.prdata[`HWDOG_STAT_EN_BIT] = st_r.en;
          st_nxt.rsp.prdata[`HWDOG_STAT_ARM_BIT] =
            (st_r.key == HWDOG_KEY_ARMED);
          st_nxt.rsp.prdata[`HWDOG_STAT_RST_BIT] = st_r.wdog_rst;
        end
      end
    end
    else if (acc)
    begin
      // keep the answer steady until the master releases
      st_nxt.rsp.prdata = st_r.rsp.prdata;
    end

    // prescale select, taken at any time
    if (wr_pre)
    begin
      st_nxt.pre_sel = apb_req.pwdata[`HWDOG_PRE_SEL_MSB:0];
    end

    // never restarted by keys: the first step after service may come early
    // machine cycle divider runs free with the oscillator
    // [R10] wraps after twelve clocks
    if (mc_tick)
    begin
      st_nxt.mc_div = 4'h0;
    end
    else
    begin
      st_nxt.mc_div = 4'(st_r.mc_div + 4'h1);
    end

    // key tracker; ignored while a reset pulse is out
    if (wr_key && !st_r.wdog_rst)
    begin
      case (st_r.key)
        HWDOG_KEY_IDLE:
        begin
          // [R2] first key arms the tracker
          if (apb_req.pwdata[7:0] == `HWDOG_KEY_FIRST)
          begin
            st_nxt.key = HWDOG_KEY_ARMED;
          end
        end
        HWDOG_KEY_ARMED:
        begin
          // [R11] a repeated first key stays armed; anything else disarms
          if (apb_req.pwdata[7:0] == `HWDOG_KEY_FIRST)
          begin
            st_nxt.key = HWDOG_KEY_ARMED;
          end
          else
          begin
            st_nxt.key = HWDOG_KEY_IDLE;
          end
        end
        default:
        begin
          st_nxt.key = HWDOG_KEY_IDLE;
        end
      endcase
    end

    // counting while enabled
    if (st_r.en && mc_tick)
    begin
      // [R9] prescaler divides machine cycles
      if (st_r.pre == pre_mask)
      begin
        st_nxt.pre = 7'h00;
      end
      else
      begin
        st_nxt.pre = 7'(st_r.pre + 7'h01);
      end
    end

    // [R3] advance once per scaled machine cycle
    if (cnt_tick)
    begin
      st_nxt.cnt = 14'(st_r.cnt + 14'h0001);
    end

    // [R5] complete pair restarts the count
    if (key_done)
    begin
      // [R2] pair also turns counting on
      st_nxt.en = 1'b1;
      st_nxt.cnt = 14'h0000;
      st_nxt.pre = 7'h00;
    end

    // a pair on the overflow edge wins, so late service still rescues
    // [R6] terminal count fires the device reset
    if (cnt_tick && (st_r.cnt == `HWDOG_CNT_TOP) && !key_done)
    begin
      // [R4] besides reset, only overflow clears the enable
      st_nxt.en = 1'b0;
      st_nxt.key = HWDOG_KEY_IDLE;
      st_nxt.cnt = 14'h0000;
      st_nxt.pre = 7'h00;
      st_nxt.wdog_rst = 1'b1;
      st_nxt.rst_cnt = 7'h00;
    end

    // [R7] hold the pulse for its full length
    if (st_r.wdog_rst)
    begin
      if (st_r.rst_cnt == RST_LAST)
      begin
        st_nxt.wdog_rst = 1'b0;
        st_nxt.rst_cnt = 7'h00;
      end
      else
      begin
        st_nxt.rst_cnt = 7'(st_r.rst_cnt + 7'h01);
      end
    end
  end

  //----------------------------------------------------------------------
  // state register
  //----------------------------------------------------------------------

  // [R1] reset leaves the watchdog off
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_r.rsp.pready <= 1'b0;
      st_r.rsp.prdata <= 32'h00000000;
      st_r.rsp.pslverr <= 1'b0;
      st_r.en <= 1'b0;
      st_r.key <= HWDOG_KEY_IDLE;
      st_r.mc_div <= 4'h0;
      st_r.pre <= 7'h00;
      st_r.pre_sel <= `HWDOG_PRE_SEL_RST;
      st_r.cnt <= 14'h0000;
      st_r.rst_cnt <= 7'h00;
      st_r.wdog_rst <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // outputs come straight from flops
  assign apb_rsp = st_r.rsp;
  assign wdog_rst = st_r.wdog_rst;

  //----------------------------------------------------------------------
  // checks
  //----------------------------------------------------------------------

  // length of the current reset pulse, for the pulse check
  logic [7:0] pulse_len_r;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pulse_len_r <= 8'h00;
    end
    else if (st_r.wdog_rst)
    begin
      pulse_len_r <= 8'(pulse_len_r + 8'h01);
    end
    else
    begin
      pulse_len_r <= 8'h00;
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  chk_off_until_key: assert property ( // [R1]
    !st_r.en && !key_done |=> !st_r.en)
    else $error("watchdog enabled without a key pair");

  chk_key_enable: assert property ( // [R2]
    key_done |=> st_r.en && st_r.cnt == 14'h0000)
    else $error("key pair did not enable the watchdog");

  chk_count_step: assert property ( // [R3]
    cnt_tick && st_r.cnt != `HWDOG_CNT_TOP && !key_done
    |=> st_r.cnt == $past(st_r.cnt) + 14'h0001)
    else $error("counter did not advance by one");

  chk_no_disable: assert property ( // [R4]
    $fell(st_r.en) |-> st_r.wdog_rst && st_r.rst_cnt == 7'h00)
    else $error("watchdog disabled without overflow");

  chk_service_clear: assert property ( // [R5]
    st_r.en && key_done |=> st_r.cnt == 14'h0000 && st_r.pre == 7'h00)
    else $error("service pair did not clear the count");

  chk_overflow_rst: assert property ( // [R6]
    cnt_tick && st_r.cnt == `HWDOG_CNT_TOP && !key_done
    |=> wdog_rst && !st_r.en)
    else $error("overflow did not raise the reset pulse");

  // pulse_len_r already holds the full count on the edge that sees the fall
  chk_pulse_len: assert property ( // [R7]
    $fell(wdog_rst) |-> pulse_len_r == 8'h60)
    else $error("reset pulse length is not 96 clocks");

  chk_key_read_zero: assert property ( // [R8]
    apb_req.psel && !apb_req.penable && !apb_req.pwrite
    && apb_req.paddr[11:2] == `HWDOG_KEY_IDX
    |=> apb_rsp.prdata == 32'h00000000 && apb_rsp.pready)
    else $error("key register read returned data");

  chk_prescale_gap: assert property ( // [R9]
    cnt_tick && st_r.pre_sel == 3'h1 && !key_done
    |=> !cnt_tick [*8])
    else $error("prescaled tick came too soon");

  chk_mc_rate: assert property ( // [R10]
    mc_tick |-> ##12 mc_tick)
    else $error("machine cycle is not twelve clocks");

  chk_bad_second: assert property ( // [R11]
    wr_key && st_r.key == HWDOG_KEY_ARMED
    && apb_req.pwdata[7:0] != `HWDOG_KEY_SECOND
    && apb_req.pwdata[7:0] != `HWDOG_KEY_FIRST
    |=> st_r.key == HWDOG_KEY_IDLE && st_r.en == $past(st_r.en))
    else $error("wrong second value not discarded");

  // a pulse in progress blocks every key, so no early re-enable
  chk_pulse_no_key: assert property ( // [R4]
    wr_key && st_r.wdog_rst |=> !st_r.en)
    else $error("key accepted during reset pulse");

  // a disabled watchdog keeps its count at zero
  chk_idle_count: assert property ( // [R1]
    !st_r.en |-> st_r.cnt == 14'h0000)
    else $error("disabled watchdog has a count");

  // pready is a one-cycle answer; a stuck pready would repeat writes
  chk_ready_single: assert property ( // [R8]
    st_r.rsp.pready |=> !st_r.rsp.pready)
    else $error("ready held for more than one cycle");

  // main scenarios: first enable, service, overflow, bad key, pulse end
  cov_enable: cover property (key_done && !st_r.en);
  cov_service: cover property (key_done && st_r.en);
  cov_overflow: cover property ($rose(wdog_rst));
  cov_bad_key: cover property (wr_key && st_r.key == HWDOG_KEY_ARMED
    && apb_req.pwdata[7:0] == 8'h00);
  cov_pulse_end: cover property ($fell(wdog_rst));

endmodule // hwdog_top

// [test/hwdog_tb.sv]
// self-checking testbench of the hardware watchdog block
`timescale 1ns/1ps
`include "hwdog_defs.svh"

// compare one value, count it, report a difference at once
`define CHK(nm, exp, got) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) \
    begin \
      num_errors++; \
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, got); \
    end \
  end

module testbench;
  import hwdog_pkg::*;

  //----------------------------------------------------------------
  // signals and addresses
  //----------------------------------------------------------------
  localparam logic [11:0] KEY_A = {`HWDOG_KEY_IDX, 2'b00};
  localparam logic [11:0] PRE_A = {`HWDOG_PRE_IDX, 2'b00};
  localparam logic [11:0] STAT_A = {`HWDOG_STAT_IDX, 2'b00};
  localparam logic [11:0] BAD_A = 12'h2A4; // unmapped word
  localparam int TOUT = 16384 * `HWDOG_MC_CYC; // sel 0 time-out
  // first step lands 1 to 12 clocks after service and the wait loop
  // sees the pulse one edge late, so the window is TOUT-10..TOUT+1
  localparam int TOUT_LO = TOUT - 10;
  localparam int TOUT_HI = TOUT + 1;
  logic pclk;
  logic presetn;
  hwdog_apb_req_s apb_req;
  hwdog_apb_rsp_s apb_rsp;
  logic wdog_rst;
  int num_errors;
  int comparisons;
  int hi_cnt; // cycles seen with the reset pulse high
  int n;
  logic [31:0] rd;
  logic err;

  hwdog_top dut
  (
    .pclk(pclk),
    .presetn(presetn),
    .apb_req(apb_req),
    .apb_rsp(apb_rsp),
    .wdog_rst(wdog_rst)
  );

  // 200 MHz clock
  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // pulse width monitor, sampled before each edge's updates land
  always @(posedge pclk)
  begin
    if (wdog_rst === 1'b1)
      hi_cnt++;
  end

  //----------------------------------------------------------------
  // bus tasks
  //----------------------------------------------------------------
  // one apb transfer; waits for pready, the hang guard ends a stuck wait
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [7:0] d, input logic [3:0] s);
    int w;
    @(posedge pclk);
    apb_req.psel <= 1'b1;
    apb_req.penable <= 1'b0;
    apb_req.pwrite <= wr;
    apb_req.paddr <= a;
    apb_req.pwdata <= {24'h0, d};
    apb_req.pstrb <= s;
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    w = 0;
    do
    begin
      @(posedge pclk);
      w++;
    end
    while (apb_rsp.pready !== 1'b1);
    // pready must stand at the completing edge
    `CHK("pready", 1'b1, apb_rsp.pready)
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask

  // byte write with the low strobe set
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, d, 4'h1);
  endtask

  // read and compare the whole word
  task automatic rd_chk(input string nm, input logic [11:0] a,
                        input logic [31:0] e);
    apb(1'b0, a, 8'h00, 4'h0);
    `CHK(nm, e, rd)
  endtask

  // full key pair
  task automatic key_pair();
    wr(KEY_A, `HWDOG_KEY_FIRST);
    wr(KEY_A, `HWDOG_KEY_SECOND);
  endtask

  // verdict and end of run
  task automatic summarize();
    if (num_errors == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  //----------------------------------------------------------------
  // tests
  //----------------------------------------------------------------
  initial
  begin
    num_errors = 0;
    comparisons = 0;
    hi_cnt = 0;
    presetn = 1'b0;
    apb_req = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk("status_after_reset", STAT_A, 32'h0);
    rd_chk("prescale_after_reset", PRE_A, 32'h0);
    rd_chk("key_reads_zero", KEY_A, 32'h0);
    apb(1'b0, BAD_A, 8'h00, 4'h0);
    `CHK("unmapped_error", 1'b1, err)
    // a wrong second value drops the half-done pair
    wr(KEY_A, `HWDOG_KEY_FIRST);
    rd_chk("status_first_key", STAT_A, 32'h2);
    wr(KEY_A, 8'h55);
    wr(KEY_A, `HWDOG_KEY_SECOND);
    rd_chk("status_pair_dropped", STAT_A, 32'h0);
    // writes without the low strobe do not count as keys
    apb(1'b1, KEY_A, `HWDOG_KEY_FIRST, 4'h0);
    apb(1'b1, KEY_A, `HWDOG_KEY_SECOND, 4'h0);
    rd_chk("status_no_strobe", STAT_A, 32'h0);
    // every prescale select, ending on 0 for the long run
    for (n = 7; n >= 0; n--)
    begin
      wr(PRE_A, n[7:0]);
      rd_chk("prescale_sel", PRE_A, 32'(n));
    end
    // pair with another register written in between
    wr(KEY_A, `HWDOG_KEY_FIRST);
    wr(PRE_A, 8'h00);
    wr(KEY_A, `HWDOG_KEY_SECOND);
    rd_chk("status_enabled", STAT_A, 32'h1);
    // attempts to switch it off must fail
    wr(STAT_A, 8'h00);
    wr(KEY_A, 8'h00);
    rd_chk("status_still_on", STAT_A, 32'h1);
    // reset in mid-run disables it again
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk("status_second_reset", STAT_A, 32'h0);
    // enable, service early, then time the overflow from service
    key_pair();
    repeat (2000) @(posedge pclk);
    key_pair();
    n = 0;
    while (wdog_rst !== 1'b1 && n < TOUT + 100)
    begin
      @(posedge pclk);
      n++;
    end
    `CHK("timeout_window", 1'b1, 1'(n >= TOUT_LO && n <= TOUT_HI))
    // keys during the pulse are ignored; overflow disables
    key_pair();
    rd_chk("status_in_pulse", STAT_A, 32'h4);
    n = 0;
    while (wdog_rst !== 1'b0 && n < 200)
    begin
      @(posedge pclk);
      n++;
    end
    @(posedge pclk);
    `CHK("pulse_width", 96, hi_cnt)
    rd_chk("status_after_pulse", STAT_A, 32'h0);
    key_pair();
    rd_chk("status_reenabled", STAT_A, 32'h1);
    summarize();
  end

  // hang guard, well past the expected run length
  initial
  begin
    #1300000;
    num_errors++;
    summarize();
  end

endmodule // testbench
